/* logic/buck_channel_three_control_regs.sv */
// Register bank and digital control of the third buck channel.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: Address 30h bits 5:0 hold the read/write standby voltage code.
// RULE2: Address 33h bits 5:0 hold the read/write active voltage code.
// RULE3: Address 33h bit 6 holds the read/write voltage span select.
// RULE4: Span 0 decodes into 0.8 to 2.2 V, span 1 into 1.3 to 4.4 V.
// RULE5: Code zero is adjustable; low span flat 0.800 then 25 mV steps.
// RULE6: Host checks the target fits the current span before changing span.
// RULE7: Address 32h bit 2 unmasks the output fault; zero masks it.
// RULE8: Read-only bits ignore writes; here all but the status bit at 32h bit 1 read as zero.
// RULE9: PWM switching runs at a fixed 1.6 MHz.
// RULE10: Light load moves control to PFM; heavier load returns to PWM.
// RULE11: Channel runs only with enable pin high and enable bit set.
// RULE12: Power-good status bit drops to zero when output is low.
// RULE13: Voltage set pin low uses active code, high uses standby code.
// RULE14: Masked fault is not reported, but the status bit still updates.
module buck_channel_three_control_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port from the serial interface
  input wire bctl_pkg::bctl_req_t regReq,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // Pins and analog status
  input wire logic enablePin,
  input wire logic voltageSetPin,
  input wire logic powerGoodIn,
  input wire logic lightLoadIn,
  // Converter control
  output logic channelEnable,
  output logic [12:0] targetMv,
  output logic [12:0] pgThresholdMv,
  output logic adjustMode,
  output logic switchTick,
  output logic pfmMode,
  // Fault signalling
  output logic faultReport
);

  logic [5:0] standbyCode_ff;
  logic [5:0] activeCode_ff;
  logic spanSel_ff;
  logic enBit_ff;
  logic unmask_ff;
  logic pgStatus_ff;
  logic [7:0] rdData_ff;
  logic rdValid_ff;
  logic [5:0] selCode_ff;
  logic [12:0] targetMv_ff;
  logic [12:0] threshMv_ff;
  logic adjust_ff;
  logic chanEn_ff;
  logic fault_ff;
  logic tick_ff;
  logic [7:0] acc_ff;
  logic [7:0] nxt_acc;
  logic nxt_tick;
  bctl_pkg::bctl_mode_t mode_ff;
  bctl_pkg::bctl_mode_t nxt_mode;
  logic [3:0] pinSync;
  logic enSync;
  logic vselSync;
  logic pgSync;
  logic lightSync;
  logic [7:0] rdByte;
  logic wrStandby;
  logic wrCtrl;
  logic wrActive;
  bctl_pkg::bctl_volt_t decVolt;
  logic [12:0] decThresh;

  bctl_sync #(
    .W(4)
  ) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .asyncIn({enablePin, voltageSetPin, powerGoodIn, lightLoadIn}),
    .syncOut(pinSync)
  );

  assign enSync = pinSync[3];
  assign vselSync = pinSync[2];
  assign pgSync = pinSync[1];
  assign lightSync = pinSync[0];

  // Address decode for writes; other addresses are silently ignored.
  always_comb begin
    wrStandby = 1'b0;
    wrCtrl = 1'b0;
    wrActive = 1'b0;
    if (!regReq.wrEn) begin
      wrStandby = 1'b0;
    end else if (regReq.addr == bctl_pkg::ADDR_STANDBY) begin
      wrStandby = 1'b1;
    end else if (regReq.addr == bctl_pkg::ADDR_CTRL) begin
      wrCtrl = 1'b1;
    end else if (regReq.addr == bctl_pkg::ADDR_ACTIVE) begin
      wrActive = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      standbyCode_ff <= bctl_pkg::RST_STANDBY_CODE;
    end else if (wrStandby) begin
      standbyCode_ff <= regReq.wrData[bctl_pkg::CODE_MSB:0]; // see RULE1
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      activeCode_ff <= bctl_pkg::RST_ACTIVE_CODE;
      spanSel_ff <= bctl_pkg::RST_SPAN;
    end else if (wrActive) begin
      activeCode_ff <= regReq.wrData[bctl_pkg::CODE_MSB:0]; // see RULE2
      spanSel_ff <= regReq.wrData[bctl_pkg::SPAN_BIT]; // see RULE3
    end
  end

  // Bit 1 of this byte is status only, so writes leave it alone.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      enBit_ff <= bctl_pkg::RST_EN_BIT;
      unmask_ff <= bctl_pkg::RST_UNMASK;
    end else if (wrCtrl) begin
      enBit_ff <= regReq.wrData[bctl_pkg::EN_BIT];
      unmask_ff <= regReq.wrData[bctl_pkg::UNMASK_BIT]; // see RULE7
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pgStatus_ff <= 1'b0;
    end else begin
      pgStatus_ff <= pgSync; // see RULE12
    end
  end

  // Read mux; read-only bits other than the power-good status bit, and unmapped bits, return zero.
  always_comb begin
    rdByte = 8'h00;
    if (regReq.addr == bctl_pkg::ADDR_STANDBY) begin
      rdByte = {2'b00, standbyCode_ff}; // see RULE8
    end else if (regReq.addr == bctl_pkg::ADDR_RESERVED) begin
      rdByte = 8'h00; // see RULE8
    end else if (regReq.addr == bctl_pkg::ADDR_CTRL) begin
      rdByte = {5'h00, unmask_ff, pgStatus_ff, enBit_ff};
    end else if (regReq.addr == bctl_pkg::ADDR_ACTIVE) begin
      rdByte = {1'b0, spanSel_ff, activeCode_ff};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdData_ff <= 8'h00;
      rdValid_ff <= 1'b0;
    end else begin
      rdValid_ff <= regReq.rdEn;
      if (regReq.rdEn) begin
        rdData_ff <= rdByte;
      end
    end
  end

  // A span change takes effect at once; the host must pick codes with care.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      selCode_ff <= bctl_pkg::RST_ACTIVE_CODE;
    end else begin
      selCode_ff <= vselSync ? standbyCode_ff : activeCode_ff; // see RULE13
    end
  end

  bctl_vdecode u_vdecode (
    .code(selCode_ff),
    .spanSel(spanSel_ff),
    .volt(decVolt),
    .thresholdMv(decThresh)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      targetMv_ff <= 13'h0000;
      threshMv_ff <= 13'h0000;
      adjust_ff <= 1'b0;
    end else begin
      targetMv_ff <= decVolt.mv; // see RULE4 see RULE5
      threshMv_ff <= decThresh;
      adjust_ff <= decVolt.adjust;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      chanEn_ff <= 1'b0;
    end else begin
      chanEn_ff <= enSync && enBit_ff; // see RULE11
    end
  end

  // A disabled channel never reports a fault, whatever the comparator says.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fault_ff <= 1'b0;
    end else begin
      fault_ff <= chanEn_ff && unmask_ff && !pgSync; // see RULE14
    end
  end

  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      bctl_pkg::MODE_PWM: begin
        if (lightSync) begin
          nxt_mode = bctl_pkg::MODE_PFM; // see RULE10
        end
      end
      bctl_pkg::MODE_PFM: begin
        if (!lightSync) begin
          nxt_mode = bctl_pkg::MODE_PWM; // see RULE10
        end
      end
      default: begin
        nxt_mode = bctl_pkg::MODE_PWM;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_ff <= bctl_pkg::MODE_PWM;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // 1.6 MHz is not a whole divide of the core clock, so the tick spacing
  // is six or seven cycles, seven once in every four ticks, to hold the average rate.
  always_comb begin
    nxt_acc = acc_ff + bctl_pkg::PWM_ACC_STEP;
    nxt_tick = 1'b0;
    if (nxt_acc >= bctl_pkg::PWM_ACC_MOD) begin
      nxt_acc = nxt_acc - bctl_pkg::PWM_ACC_MOD; // see RULE9
      nxt_tick = chanEn_ff && (mode_ff == bctl_pkg::MODE_PWM);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acc_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      tick_ff <= nxt_tick;
    end
  end

  assign regRdData = rdData_ff;
  assign regRdValid = rdValid_ff;
  assign channelEnable = chanEn_ff;
  assign targetMv = targetMv_ff;
  assign pgThresholdMv = threshMv_ff;
  assign adjustMode = adjust_ff;
  assign switchTick = tick_ff;
  assign pfmMode = (mode_ff == bctl_pkg::MODE_PFM);
  assign faultReport = fault_ff;

  // Helper logic read only by the checks below.
  logic [3:0] tickGap_ff;
  logic [12:0] lowStepMv;
  always_ff @(posedge core_clk) begin
    if (sys_rst || !chanEn_ff || mode_ff != bctl_pkg::MODE_PWM) begin
      tickGap_ff <= 4'h8;
    end else if (tick_ff) begin
      tickGap_ff <= 4'h1;
    end else if (tickGap_ff != 4'hF) begin
      tickGap_ff <= tickGap_ff + 4'h1;
    end
  end
  assign lowStepMv = bctl_pkg::LOW_BASE_MV + bctl_pkg::LOW_STEP_MV *
                     ({7'h00, selCode_ff} - 13'h0007);

  sequence s_wr_standby;
    regReq.wrEn && regReq.addr == bctl_pkg::ADDR_STANDBY;
  endsequence
  sequence s_rd_standby;
    regReq.rdEn && regReq.addr == bctl_pkg::ADDR_STANDBY;
  endsequence

  property p_standby_wr;
    @(posedge core_clk) disable iff (sys_rst)
    s_wr_standby |=> standbyCode_ff == $past(regReq.wrData[5:0]);
  endproperty
  a_standby_wr: assert property (p_standby_wr) // see RULE1
    else $error("standby code not stored");

  property p_active_wr;
    @(posedge core_clk) disable iff (sys_rst)
    wrActive |=> activeCode_ff == $past(regReq.wrData[5:0]) &&
                 spanSel_ff == $past(regReq.wrData[6]);
  endproperty
  a_active_wr: assert property (p_active_wr) // see RULE2 see RULE3
    else $error("active code or span not stored");

  property p_span_range;
    @(posedge core_clk) disable iff (sys_rst)
    !decVolt.adjust ##1 $stable(spanSel_ff) |->
      (spanSel_ff ? (targetMv_ff >= bctl_pkg::HIGH_MIN_MV &&
                     targetMv_ff <= bctl_pkg::HIGH_MAX_MV)
                  : (targetMv_ff >= bctl_pkg::LOW_MIN_MV &&
                     targetMv_ff <= bctl_pkg::LOW_MAX_MV));
  endproperty
  a_span_range: assert property (p_span_range) // see RULE4
    else $error("target outside selected span");

  property p_low_step;
    @(posedge core_clk) disable iff (sys_rst)
    (!spanSel_ff && selCode_ff > 6'h07 && selCode_ff != 6'h22) |=>
      targetMv_ff == $past(lowStepMv) && !adjust_ff;
  endproperty
  a_low_step: assert property (p_low_step) // see RULE5
    else $error("low span step decode wrong");

  property p_ro_read;
    @(posedge core_clk) disable iff (sys_rst)
    s_wr_standby ##1 !regReq.wrEn ##1 s_rd_standby |=>
      regRdValid && regRdData[7:6] == 2'b00 &&
      regRdData[5:0] == $past(regReq.wrData[5:0], 3);
  endproperty
  a_ro_read: assert property (p_ro_read) // see RULE8
    else $error("read-only bits or readback wrong");

  property p_tick_gap;
    @(posedge core_clk) disable iff (sys_rst)
    tick_ff && tickGap_ff < 4'h8 |-> tickGap_ff inside {4'h6, 4'h7};
  endproperty
  a_tick_gap: assert property (p_tick_gap) // see RULE9
    else $error("switching tick spacing wrong");

  property p_pfm_follow;
    @(posedge core_clk) disable iff (sys_rst)
    lightSync [*3] |-> pfmMode && !switchTick;
  endproperty
  a_pfm_follow: assert property (p_pfm_follow) // see RULE10
    else $error("light load did not select PFM");

  property p_enable;
    @(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> channelEnable == $past(enSync && enBit_ff);
  endproperty
  a_enable: assert property (p_enable) // see RULE11
    else $error("channel enable wrong");

  property p_pgood;
    @(posedge core_clk) disable iff (sys_rst)
    !pgSync |=> !pgStatus_ff ##1
      (regReq.addr != bctl_pkg::ADDR_CTRL || rdByte[1] == pgStatus_ff);
  endproperty
  a_pgood: assert property (p_pgood) // see RULE12
    else $error("power-good status not cleared");

  property p_voltage_set_pin;
    @(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> selCode_ff == ($past(vselSync) ? $past(standbyCode_ff)
                                            : $past(activeCode_ff));
  endproperty
  a_voltage_set_pin: assert property (p_voltage_set_pin) // see RULE13
    else $error("voltage set pin selects wrong code");

  property p_fault_mask;
    @(posedge core_clk) disable iff (sys_rst)
    !unmask_ff |=> !faultReport;
  endproperty
  a_fault_mask: assert property (p_fault_mask) // see RULE7 see RULE14
    else $error("masked fault was reported");

endmodule : buck_channel_three_control_regs
`default_nettype wire

/* logic/bctl_pkg.sv */
// Shared constants and types for the third buck channel control registers.
`default_nettype none
package bctl_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_STANDBY = 8'h30;
  localparam logic [7:0] ADDR_RESERVED = 8'h31;
  localparam logic [7:0] ADDR_CTRL = 8'h32;
  localparam logic [7:0] ADDR_ACTIVE = 8'h33;

  // Field positions.
  localparam int CODE_MSB = 5;
  localparam int SPAN_BIT = 6;
  localparam int EN_BIT = 0;
  localparam int PG_BIT = 1;
  localparam int UNMASK_BIT = 2;

  // Values after reset; the device defaults are set per ordering option.
  localparam logic [5:0] RST_STANDBY_CODE = 6'h20;
  localparam logic [5:0] RST_ACTIVE_CODE = 6'h20;
  localparam logic RST_SPAN = 1'b0;
  localparam logic RST_EN_BIT = 1'b0;
  localparam logic RST_UNMASK = 1'b0;

  // Voltage table figures in millivolts.
  localparam logic [12:0] LOW_BASE_MV = 13'h0320;
  localparam logic [12:0] LOW_STEP_MV = 13'h0019;
  localparam logic [12:0] HIGH_BASE_MV = 13'h04E2;
  localparam logic [12:0] HIGH_STEP_MV = 13'h0032;
  localparam logic [12:0] LOW_ODD_MV = 13'h05C8;
  localparam logic [12:0] FB_LOW_MV = 13'h0271;
  localparam logic [12:0] FB_HIGH_MV = 13'h04E2;
  localparam logic [12:0] LOW_MIN_MV = 13'h0320;
  localparam logic [12:0] LOW_MAX_MV = 13'h0898;
  localparam logic [12:0] HIGH_MIN_MV = 13'h0514;
  localparam logic [12:0] HIGH_MAX_MV = 13'h1130;
  localparam logic [5:0] CODE_ADJUST = 6'h00;
  localparam logic [5:0] LOW_FLAT_LAST = 6'h07;
  localparam logic [5:0] LOW_ODD_CODE = 6'h22;
  localparam logic [15:0] PG_MARGIN_PCT = 16'h0006;
  localparam logic [15:0] PCT_DIV = 16'h0064;

  // Switching rate as a fractional accumulator on the core clock.
  localparam int CLK_HZ = 10_000_000;
  localparam int PWM_HZ = 1_600_000;
  localparam int ACC_UNIT = 100_000;
  localparam logic [7:0] PWM_ACC_STEP = 8'(PWM_HZ / ACC_UNIT);
  localparam logic [7:0] PWM_ACC_MOD = 8'(CLK_HZ / ACC_UNIT);

  // One register access from the serial interface.
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } bctl_req_t;

  // Decoded output voltage.
  typedef struct packed {
    logic [12:0] mv;
    logic adjust;
  } bctl_volt_t;

  typedef enum logic [1:0] {
    MODE_PWM = 2'b01,
    MODE_PFM = 2'b10
  } bctl_mode_t;

endpackage : bctl_pkg
`default_nettype wire

/* logic/bctl_sync.sv */
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module bctl_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Data
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;

endmodule : bctl_sync
`default_nettype wire

/* logic/bctl_vdecode.sv */
// Voltage code decoder for the third buck channel.
`timescale 1ns/1ps
`default_nettype none
module bctl_vdecode (
  // Code and range
  input wire logic [5:0] code,
  input wire logic spanSel,
  // Decoded target
  output bctl_pkg::bctl_volt_t volt,
  output logic [12:0] thresholdMv
);

  logic [12:0] code13;
  logic [15:0] margin;

  assign code13 = {7'h00, code};

  always_comb begin
    volt.adjust = (code == bctl_pkg::CODE_ADJUST);
    if (volt.adjust) begin
      // External divider mode: the output pin becomes a feedback input.
      volt.mv = spanSel ? bctl_pkg::FB_HIGH_MV : bctl_pkg::FB_LOW_MV;
    end else if (spanSel) begin
      volt.mv = bctl_pkg::HIGH_BASE_MV + bctl_pkg::HIGH_STEP_MV * code13;
    end else if (code <= bctl_pkg::LOW_FLAT_LAST) begin
      volt.mv = bctl_pkg::LOW_BASE_MV;
    end else if (code == bctl_pkg::LOW_ODD_CODE) begin
      // This entry breaks the 25 mV pattern and is kept as tabulated.
      volt.mv = bctl_pkg::LOW_ODD_MV;
    end else begin
      volt.mv = bctl_pkg::LOW_BASE_MV + bctl_pkg::LOW_STEP_MV *
                (code13 - {7'h00, bctl_pkg::LOW_FLAT_LAST});
    end
  end

  // Power-good trip point sits a fixed percentage under the target.
  assign margin = ({3'h0, volt.mv} * bctl_pkg::PG_MARGIN_PCT) /
                  bctl_pkg::PCT_DIV;
  assign thresholdMv = volt.mv - margin[12:0];

endmodule : bctl_vdecode
`default_nettype wire

/* tb/bctl_host_model.sv */
// Behavioural host that issues single-byte register accesses.
`timescale 1ns/1ps
`default_nettype none
module bctl_host_model (
  // Clock
  input wire logic core_clk,
  // Register port
  output var bctl_pkg::bctl_req_t regReq,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid
);
  initial regReq = '0;

  // Between accesses address and data carry inverted values, so a stale
  // latch of them inside the block cannot pass unseen.
  task automatic idle(input logic [7:0] a, input logic [7:0] d);
    regReq = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: ~d};
  endtask : idle

  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(negedge core_clk);
    idle(a, d);
  endtask : write

  task automatic read(input logic [7:0] a, output logic [7:0] d,
                      output logic ok);
    @(negedge core_clk);
    regReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h5A};
    @(negedge core_clk);
    idle(a, 8'h5A);
    // The valid flag stands only in the cycle right after the strobe; the data holds.
    ok = (regRdValid === 1'b1);
    d = regRdData;
    @(negedge core_clk);
    if (regRdValid !== 1'b0 || regRdData !== d) begin
      ok = 1'b0;
    end
  endtask : read
endmodule : bctl_host_model
`default_nettype wire

/* tb/buck_channel_three_control_regs_test.sv */
// Self-checking testbench for the third buck channel register bank.
`timescale 1ns/1ps
`default_nettype none
module buck_channel_three_control_regs_test;
  logic core_clk, sys_rst, enablePin, voltageSetPin, powerGoodIn, lightLoadIn;
  bctl_pkg::bctl_req_t regReq;
  logic [7:0] regRdData;
  logic regRdValid, channelEnable, adjustMode, switchTick, pfmMode;
  logic faultReport;
  logic [12:0] targetMv, pgThresholdMv;
  int failures = 0;
  int total_checks = 0;

  buck_channel_three_control_regs u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .regReq(regReq),
    .regRdData(regRdData), .regRdValid(regRdValid),
    .enablePin(enablePin), .voltageSetPin(voltageSetPin),
    .powerGoodIn(powerGoodIn), .lightLoadIn(lightLoadIn),
    .channelEnable(channelEnable), .targetMv(targetMv),
    .pgThresholdMv(pgThresholdMv), .adjustMode(adjustMode),
    .switchTick(switchTick), .pfmMode(pfmMode), .faultReport(faultReport)
  );

  bctl_host_model u_host (
    .core_clk(core_clk), .regReq(regReq),
    .regRdData(regRdData), .regRdValid(regRdValid)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  task automatic settle();
    repeat (8) @(negedge core_clk);
  endtask : settle

  // A missing read answer shows up as a mismatch in bit 8.
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_host.read(a, d, ok);
    check({7'h00, ok, d}, {8'h01, exp});
  endtask : rd_check

  task automatic count_ticks(input logic [15:0] exp);
    int n;
    n = 0;
    repeat (100) begin
      @(negedge core_clk);
      if (switchTick === 1'b1) n++;
    end
    check(16'(n), exp);
  endtask : count_ticks

  function automatic logic [12:0] exp_mv(input logic [5:0] c, input logic s);
    if (s) return (c == 6'h00) ? 13'h04E2 : 13'h04E2 + 13'(c) * 13'h0032;
    if (c == 6'h00) return 13'h0271;
    if (c <= 6'h07) return 13'h0320;
    if (c == 6'h22) return 13'h05C8;
    return 13'h0320 + 13'(c - 6'h07) * 13'h0019;
  endfunction : exp_mv

  task automatic test_reset_values();
    rd_check(8'h30, 8'h20);
    rd_check(8'h31, 8'h00);
    rd_check(8'h32, 8'h02);
    rd_check(8'h33, 8'h20);
    check(16'(targetMv), 16'h0591);
    check(16'(channelEnable), 16'h0000);
  endtask : test_reset_values

  task automatic test_access();
    u_host.write(8'h30, 8'hFF);
    rd_check(8'h30, 8'h3F);
    u_host.write(8'h31, 8'hFF);
    rd_check(8'h31, 8'h00);
    u_host.write(8'h32, 8'hFF);
    rd_check(8'h32, 8'h07);
    u_host.write(8'h33, 8'hFF);
    rd_check(8'h33, 8'h7F);
    u_host.write(8'h33, 8'h15);
    rd_check(8'h33, 8'h15);
    rd_check(8'h34, 8'h00);
    u_host.write(8'h32, 8'h00);
  endtask : test_access

  // The span rises once, after the low sweep ends at the top code, whose
  // voltage the high span covers as well.
  task automatic test_decode();
    logic [12:0] e;
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 64; c++) begin
        u_host.write(8'h33, {1'b0, 1'(s), 6'(c)});
        settle();
        e = exp_mv(6'(c), 1'(s));
        check(16'(targetMv), 16'(e));
        check(16'(adjustMode), 16'(c == 0));
        if (c != 0 && (e % 50) == 0) begin
          check(16'(pgThresholdMv), 16'(e - e * 6 / 100));
        end
      end
    end
  endtask : test_decode

  task automatic test_set_pin();
    u_host.write(8'h30, 8'h0F);
    u_host.write(8'h33, 8'h20);
    settle();
    check(16'(targetMv), 16'h0591);
    voltageSetPin = 1'b1;
    settle();
    check(16'(targetMv), 16'h03E8);
    voltageSetPin = 1'b0;
    settle();
    check(16'(targetMv), 16'h0591);
  endtask : test_set_pin

  task automatic test_enable();
    for (int i = 0; i < 4; i++) begin
      enablePin = i[1];
      u_host.write(8'h32, {7'h00, i[0]});
      settle();
      check(16'(channelEnable), 16'(i == 3));
    end
  endtask : test_enable

  task automatic test_fault();
    powerGoodIn = 1'b0;
    settle();
    check(16'(faultReport), 16'h0000);
    rd_check(8'h32, 8'h01);
    u_host.write(8'h32, 8'h05);
    settle();
    check(16'(faultReport), 16'h0001);
    powerGoodIn = 1'b1;
    settle();
    check(16'(faultReport), 16'h0000);
    rd_check(8'h32, 8'h07);
  endtask : test_fault

  task automatic test_switching();
    count_ticks(16'h0010);
    lightLoadIn = 1'b1;
    settle();
    check(16'(pfmMode), 16'h0001);
    count_ticks(16'h0000);
    lightLoadIn = 1'b0;
    settle();
    check(16'(pfmMode), 16'h0000);
    count_ticks(16'h0010);
    u_host.write(8'h32, 8'h04);
    settle();
    count_ticks(16'h0000);
  endtask : test_switching

  initial begin
    #(20000 * 100);
    failures++;
    $display("watchdog expired before the tests ended");
    results();
  end

  initial begin
    sys_rst = 1'b1;
    enablePin = 1'b0;
    voltageSetPin = 1'b0;
    powerGoodIn = 1'b1;
    lightLoadIn = 1'b0;
    repeat (20) @(negedge core_clk);
    sys_rst = 1'b0;
    settle();
    test_reset_values();
    test_access();
    test_decode();
    test_set_pin();
    test_enable();
    test_fault();
    test_switching();
    results();
  end
endmodule : buck_channel_three_control_regs_test
`default_nettype wire
